// >>> hw/esf_ecc_log.sv
`timescale 1ns/1ps
`default_nettype none
// ECC error log fields with flag-driven locking
module esf_ecc_log (
  input wire logic core_clk,
  input wire logic power_good_reset,
  esf_log_if.log lg
);

  // Logged fields, sticky like the flags that guard them
  logic [$bits(lg.err_addr)-1:0] addr_ff, nxt_addr;
  logic [$bits(lg.err_syn)-1:0] syn_ff, nxt_syn;
  logic [$bits(lg.err_chan)-1:0] chan_ff, nxt_chan;
  logic [$bits(lg.err_dev)-1:0] dev_ff, nxt_dev;
  logic mb_take; // Multi-bit capture allowed
  logic sb_take; // Single-bit capture allowed

  // Capture decision; a multi-bit error wins over a single-bit one in the same cycle
  always_comb begin
    mb_take = lg.mbe_evt && !lg.mb_flag; // R9 R10 R13
    sb_take = lg.sbe_evt && !lg.sb_flag && !lg.mb_flag && !lg.mbe_evt; // R11 R12 R14
    nxt_addr = addr_ff;
    nxt_syn = syn_ff;
    nxt_chan = chan_ff;
    nxt_dev = dev_ff;
    if (mb_take || sb_take) begin
      nxt_addr = lg.err_addr;
      nxt_syn = lg.err_syn;
      nxt_dev = lg.err_dev;
    end
    // Channel is only part of the multi-bit signature
    if (mb_take) begin
      nxt_chan = lg.err_chan; // R9
    end
  end

  // Only power-good clears the log, so it survives ordinary resets
  always_ff @(posedge core_clk) begin
    if (power_good_reset) begin
      addr_ff <= '0;
      syn_ff <= '0;
      chan_ff <= '0;
      dev_ff <= '0;
    end else begin
      addr_ff <= nxt_addr;
      syn_ff <= nxt_syn;
      chan_ff <= nxt_chan;
      dev_ff <= nxt_dev;
    end
  end

  assign lg.log_addr = addr_ff;
  assign lg.log_syn = syn_ff;
  assign lg.log_chan = chan_ff;
  assign lg.log_dev = dev_ff;

  default clocking log_cb @(posedge core_clk); endclocking
  default disable iff (power_good_reset);

  AST_MBE_LOGS: assert property (lg.mbe_evt && !lg.mb_flag // R9
                                 |=> addr_ff == $past(lg.err_addr) && chan_ff == $past(lg.err_chan))
    else $error("multi-bit error not logged");
  AST_MB_LOCKED: assert property (lg.mb_flag |=> $stable(addr_ff) && $stable(syn_ff)) // R10
    else $error("log changed while multi-bit flag set");
  AST_SB_LOCKED: assert property (lg.sb_flag && !lg.mbe_evt |=> $stable(addr_ff) && $stable(dev_ff)) // R12
    else $error("log changed by single-bit error while locked");
  AST_MB_OVERWRITE: assert property (lg.sb_flag && !lg.mb_flag && lg.mbe_evt |=> syn_ff == $past(lg.err_syn)) // R13
    else $error("multi-bit error did not overwrite single-bit log");
  AST_SBE_LOGS: assert property (lg.sbe_evt && !lg.mbe_evt && !lg.sb_flag && !lg.mb_flag // R11
                                 |=> addr_ff == $past(lg.err_addr))
    else $error("single-bit error not logged");
  COV_SB_THEN_MB: cover property (lg.sb_flag && !lg.mb_flag && lg.mbe_evt);

endmodule : esf_ecc_log
`default_nettype wire

// >>> hw/esf_error_status_flags.sv
`timescale 1ns/1ps
`default_nettype none
// Sticky write-one-to-clear error status flags with message generation
module esf_error_status_flags #(
  parameter int ADDR_W = 32,
  parameter int SYN_W = 8,
  parameter int CHAN_W = 1,
  parameter int DEV_W = 2
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic power_good_reset,
  // Configuration space access
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [1:0] cfg_be,
  input wire logic [15:0] cfg_wdata,
  output logic [15:0] cfg_rdata,
  output logic cfg_rvalid,
  // Message enables held by neighbouring registers
  input wire logic [15:0] error_message_enables,
  input wire logic pci_serr_enable,
  input wire logic smi_thermal_enable,
  input wire logic sci_thermal_enable,
  // Event pulses from the memory controller, same clock
  input wire logic iso_full_evt,
  input wire logic iso_put_evt,
  input wire logic thermal_trip_evt,
  input wire logic lock_miss_evt,
  input wire logic throttle_evt,
  input wire logic sbe_evt,
  input wire logic mbe_evt,
  input wire logic [ADDR_W-1:0] ecc_err_addr,
  input wire logic [SYN_W-1:0] ecc_err_syn,
  input wire logic [CHAN_W-1:0] ecc_err_chan,
  input wire logic [DEV_W-1:0] ecc_err_dev,
  // Outgoing messages and status
  output logic serr_msg,
  output logic smi_msg,
  output logic sci_msg,
  output logic [15:0] error_status_flags,
  output logic [ADDR_W-1:0] ecc_error_address_log,
  output logic [SYN_W-1:0] ecc_syndrome_log,
  output logic [CHAN_W-1:0] ecc_channel_log,
  output logic [DEV_W-1:0] ecc_destination_log
);

  // Expands byte enables into a 16-bit lane mask
  function automatic logic [15:0] lane_mask(input logic [1:0] be);
    lane_mask = {{8{be[1]}}, {8{be[0]}}};
  endfunction

  // Sticky flags; only power-good or a write of one clears them
  logic [15:0] flags_ff, nxt_flags;
  // Message pulses and read path; cleared by the ordinary reset
  logic serr_ff, nxt_serr;
  logic smi_ff, nxt_smi;
  logic sci_ff, nxt_sci;
  logic [15:0] rdata_ff, nxt_rdata;
  logic rvalid_ff, nxt_rvalid;
  logic hit; // Access targets the status register
  logic [15:0] clr; // Write-one-to-clear request per bit
  logic [15:0] set; // Hardware set request per bit
  logic [15:0] rise; // Flags going from zero to one this cycle
  logic therm_route; // Some message path is enabled for thermal trips
  logic therm_sent; // A thermal message goes out this cycle

  esf_log_if #(.ADDR_W(ADDR_W), .SYN_W(SYN_W), .CHAN_W(CHAN_W), .DEV_W(DEV_W)) log_bus ();

  // Flag update: hardware sets take priority over a same-cycle software clear
  always_comb begin
    hit = cfg_addr == esf_pkg::ESF_STATUS_OFFSET;
    // Writing zero leaves a flag alone; reserved bits are masked off
    clr = (cfg_wr && hit) ? (cfg_wdata & lane_mask(cfg_be) & esf_pkg::ESF_IMPL_MASK) : 16'h0000; // R18 R19
    // One message type per trip is software's duty; any enabled path counts
    therm_route = (error_message_enables[esf_pkg::ESF_BIT_THERMAL] && pci_serr_enable)
                  || smi_thermal_enable || sci_thermal_enable; // R5
    // A trip while the flag is set sends nothing and so cannot set it again
    therm_sent = thermal_trip_evt && therm_route && !flags_ff[esf_pkg::ESF_BIT_THERMAL]; // R4 R6
    set = 16'h0000;
    set[esf_pkg::ESF_BIT_ISO_FULL] = iso_full_evt; // R1
    set[esf_pkg::ESF_BIT_ISO_PUT] = iso_put_evt; // R2
    set[esf_pkg::ESF_BIT_THERMAL] = therm_sent; // R4
    set[esf_pkg::ESF_BIT_LOCK_MISS] = lock_miss_evt; // R7
    set[esf_pkg::ESF_BIT_THROTTLE] = throttle_evt; // R8
    set[esf_pkg::ESF_BIT_MULTI_ECC] = mbe_evt; // R9 R13
    set[esf_pkg::ESF_BIT_SINGLE_ECC] = sbe_evt; // R11 R14
    // Flags other than thermal set whether or not any message is enabled
    nxt_flags = ((flags_ff & ~clr) | set) & esf_pkg::ESF_IMPL_MASK; // R18 R19
    // Only a zero-to-one change may raise a message; a flag already set stays quiet
    rise = set & ~flags_ff;
  end

  // Sticky flag storage; the ordinary reset is deliberately not seen here
  always_ff @(posedge core_clk) begin
    if (power_good_reset) begin
      flags_ff <= esf_pkg::ESF_STATUS_RESET; // R16
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  // Messages fire only on a zero-to-one edge, so a set flag stays quiet
  always_comb begin
    nxt_serr = pci_serr_enable && |(rise & error_message_enables & esf_pkg::ESF_IMPL_MASK); // R17 R3
    nxt_smi = therm_sent && smi_thermal_enable; // R6
    nxt_sci = therm_sent && sci_thermal_enable; // R6
    // Read returns the flags one cycle after the request
    nxt_rvalid = cfg_rd;
    nxt_rdata = 16'h0000;
    if (cfg_rd && hit) begin
      nxt_rdata = flags_ff & lane_mask(cfg_be); // R15 R19
    end
  end

  // Message and read registers
  always_ff @(posedge core_clk) begin
    if (sys_rst || power_good_reset) begin
      serr_ff <= 1'b0;
      smi_ff <= 1'b0;
      sci_ff <= 1'b0;
      rdata_ff <= 16'h0000;
      rvalid_ff <= 1'b0;
    end else begin
      serr_ff <= nxt_serr;
      smi_ff <= nxt_smi;
      sci_ff <= nxt_sci;
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  // Feed the log keeper with events and the flags that lock it
  assign log_bus.sbe_evt = sbe_evt;
  assign log_bus.mbe_evt = mbe_evt;
  assign log_bus.err_addr = ecc_err_addr;
  assign log_bus.err_syn = ecc_err_syn;
  assign log_bus.err_chan = ecc_err_chan;
  assign log_bus.err_dev = ecc_err_dev;
  assign log_bus.sb_flag = flags_ff[esf_pkg::ESF_BIT_SINGLE_ECC]; // R12
  assign log_bus.mb_flag = flags_ff[esf_pkg::ESF_BIT_MULTI_ECC]; // R10

  // Log fields, locked by the ECC flags
  esf_ecc_log u_ecc_log (
    .core_clk(core_clk),
    .power_good_reset(power_good_reset),
    .lg(log_bus.log)
  );

  assign cfg_rdata = rdata_ff;
  assign cfg_rvalid = rvalid_ff;
  assign serr_msg = serr_ff;
  assign smi_msg = smi_ff;
  assign sci_msg = sci_ff;
  assign error_status_flags = flags_ff;
  assign ecc_error_address_log = log_bus.log_addr;
  assign ecc_syndrome_log = log_bus.log_syn;
  assign ecc_channel_log = log_bus.log_chan;
  assign ecc_destination_log = log_bus.log_dev;

  // Checks watch the sticky domain; only power-good disables them
  default clocking main_cb @(posedge core_clk); endclocking
  default disable iff (power_good_reset);

  // Set paths: each run-behind event reaches its flag one edge later
  AST_ISO_FULL_SET: assert property (iso_full_evt |=> flags_ff[14]) // R1
    else $error("run-behind full flag not set");
  AST_ISO_PUT_SET: assert property (iso_put_evt |=> flags_ff[13]) // R2
    else $error("run-behind put flag not set");
  // Both run-behind flags set and nothing else rising: no message may leave
  AST_ISO_QUIET: assert property (flags_ff[14] && flags_ff[13] && !sys_rst // R3
                                  && ((set & ~flags_ff & ~esf_pkg::ESF_ISO_MASK) == 16'h0000) |=> !serr_msg)
    else $error("message repeated for a set run-behind flag");
  // Thermal flag follows the message, never the trip alone
  AST_THERM_UNSENT: assert property (!flags_ff[11] && thermal_trip_evt && !therm_route |=> !flags_ff[11]) // R4
    else $error("thermal flag set without a message");
  AST_THERM_QUIET: assert property (flags_ff[11] |=> !smi_msg && !sci_msg) // R6
    else $error("thermal message while flag set");
  AST_LOCK_SET: assert property (lock_miss_evt |=> flags_ff[9]) // R7
    else $error("lock miss flag not set");
  AST_THROTTLE_SET: assert property (throttle_evt ##1 !(cfg_wr && hit && cfg_wdata[7] && cfg_be[0]) // R8
                                     |=> flags_ff[7])
    else $error("throttle flag lost or not set");
  // Software side: the ordinary reset and zero writes leave flags alone
  AST_STICKY: assert property (sys_rst && flags_ff[0] && !clr[0] |=> flags_ff[0]) // R16
    else $error("ordinary reset cleared a sticky flag");
  AST_SERR_ON_RISE: assert property (!sys_rst && pci_serr_enable && error_message_enables[9] && lock_miss_evt // R17
                                     && !flags_ff[9] |=> serr_msg)
    else $error("no message on rising flag");
  AST_W1C: assert property (cfg_wr && hit && cfg_be[0] && cfg_wdata[0] && !sbe_evt |=> !flags_ff[0]) // R18
    else $error("write one did not clear flag");
  AST_W0_KEEP: assert property (flags_ff[1] && cfg_wr && hit && !cfg_wdata[1] |=> flags_ff[1]) // R18
    else $error("write zero cleared a flag");
  AST_RESERVED: assert property ((flags_ff & ~esf_pkg::ESF_IMPL_MASK) == 16'h0000) // R19
    else $error("reserved bit set");
  // Multi-bit flag and its log arrive together unless the log was already locked
  AST_MB_SETS: assert property (mbe_evt |=> flags_ff[1] // R9
                                ##0 (ecc_error_address_log == $past(ecc_err_addr) || $past(flags_ff[1])))
    else $error("multi-bit flag or log missing");
  // Mixed ECC order: each flag still sets whatever the other one holds
  AST_MB_OVER_SB: assert property (flags_ff[0] && mbe_evt |=> flags_ff[1]) // R13
    else $error("multi-bit flag not set over single-bit flag");
  AST_SB_AFTER_MB: assert property (flags_ff[1] && sbe_evt |=> flags_ff[0]) // R14
    else $error("single-bit flag not set after multi-bit error");
  // Clear thermal flag plus a routed trip gives both the message and the flag
  AST_SMI_SENT: assert property (thermal_trip_evt && smi_thermal_enable && !flags_ff[11] && !sys_rst // R4 R6
                                 |=> smi_msg && flags_ff[11])
    else $error("thermal trip lost while flag clear");
  // A full-width read returns the flags as they stood at the request
  AST_READ_FLAGS: assert property (cfg_rd && hit && cfg_be == 2'h3 && !sys_rst // R19
                                   |=> cfg_rvalid && cfg_rdata == $past(flags_ff))
    else $error("read data differs from flags");

  COV_THERM_SMI: cover property (smi_msg);
  COV_W1C_ECC: cover property (flags_ff[0] ##1 !flags_ff[0]);
  COV_ISO_BOTH: cover property (flags_ff[14] && flags_ff[13]);
  COV_THERM_SERR: cover property (serr_msg && flags_ff[11]);

endmodule : esf_error_status_flags
`default_nettype wire

// >>> shared/esf_log_if.sv
`timescale 1ns/1ps
`default_nettype none
// Carries ECC events, current flags and logged fields between control and log
interface esf_log_if #(
  parameter int ADDR_W = 32,
  parameter int SYN_W = 8,
  parameter int CHAN_W = 1,
  parameter int DEV_W = 2
);
  logic sbe_evt; // Correctable error seen on a read
  logic mbe_evt; // Uncorrectable error seen on a read
  logic [ADDR_W-1:0] err_addr; // Failing address
  logic [SYN_W-1:0] err_syn; // Syndrome of the failing read
  logic [CHAN_W-1:0] err_chan; // Channel of the failing read
  logic [DEV_W-1:0] err_dev; // Device of the failing read
  logic sb_flag; // Current single-bit flag
  logic mb_flag; // Current multi-bit flag
  logic [ADDR_W-1:0] log_addr; // Logged address
  logic [SYN_W-1:0] log_syn; // Logged syndrome
  logic [CHAN_W-1:0] log_chan; // Logged channel
  logic [DEV_W-1:0] log_dev; // Logged destination device

  modport ctrl (output sbe_evt, mbe_evt, err_addr, err_syn, err_chan, err_dev, sb_flag, mb_flag,
                input log_addr, log_syn, log_chan, log_dev);
  modport log (input sbe_evt, mbe_evt, err_addr, err_syn, err_chan, err_dev, sb_flag, mb_flag,
               output log_addr, log_syn, log_chan, log_dev);
endinterface : esf_log_if
`default_nettype wire

// >>> shared/esf_pkg.sv
// Functional notes
// R1: Set bit 14 when slot timer halts.
// R2: Set bit 13 on run-behind queue put.
// R3: No repeat message while iso flag set.
// R4: Thermal flag set only when message sent.
// R5: Software routes each trip to one message.
// R6: No thermal message while thermal flag set.
// R7: Set bit 9 on locked non-DRAM access.
// R8: Set bit 7 on DRAM throttling.
// R9: Multi-bit error sets bit 1, logs fields.
// R10: Multi-bit flag locks log until cleared.
// R11: Single-bit error sets bit 0, logs fields.
// R12: Single-bit flag blocks further single-bit logging.
// R13: Multi-bit overwrites single-bit log, sets flag.
// R14: Single-bit after multi-bit keeps multi log.
// R15: Software reads both ECC flags together.
// R16: Flags clear only on power-good reset.
// R17: Message on rising flag when enabled.
// R18: Flags set regardless; write one clears.
// R19: Reserved bits read zero, ignore writes.
package esf_pkg;

  // Configuration offset of the status register (two byte lanes)
  localparam logic [7:0] ESF_STATUS_OFFSET = 8'hC8;
  localparam logic [15:0] ESF_STATUS_RESET = 16'h0000;

  // Flag positions inside the status register
  localparam int ESF_BIT_ISO_FULL = 14;
  localparam int ESF_BIT_ISO_PUT = 13;
  localparam int ESF_BIT_THERMAL = 11;
  localparam int ESF_BIT_LOCK_MISS = 9;
  localparam int ESF_BIT_THROTTLE = 7;
  localparam int ESF_BIT_MULTI_ECC = 1;
  localparam int ESF_BIT_SINGLE_ECC = 0;

  // Implemented bits; everything else is reserved and reads zero
  localparam logic [15:0] ESF_IMPL_MASK = 16'h6A83;
  // Run-behind flags, used only by the message-suppression assertion
  localparam logic [15:0] ESF_ISO_MASK = 16'h6000;

endpackage : esf_pkg

// >>> verification/tb_error_status_flags.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the sticky error status flags
module tb_error_status_flags;
  logic core_clk = 1'b0; // 100 MHz clock
  logic sys_rst = 1'b1; // Ordinary reset, held at start
  logic power_good_reset = 1'b1; // Power-good reset, held at start
  logic cfg_wr = 1'b0; // Config write strobe
  logic cfg_rd = 1'b0; // Config read strobe
  logic [7:0] cfg_addr = 8'h00; // Config offset
  logic [1:0] cfg_be = 2'h0; // Byte lanes
  logic [15:0] cfg_wdata = 16'h0000; // Write-one-to-clear data
  logic [15:0] msg_en = 16'h0000; // Per-flag error message enables
  logic serr_en = 1'b0; // Global error message enable
  logic smi_en = 1'b0; // Thermal route to SMI
  logic sci_en = 1'b0; // Thermal route to SCI
  logic [6:0] evt = 7'h00; // Events: full, put, thermal, lock, throttle, mbe, sbe
  logic [31:0] e_addr = 32'h0000_0000; // Failing address; other fields derive from it
  logic [15:0] cfg_rdata;
  logic cfg_rvalid;
  logic serr_msg;
  logic smi_msg;
  logic sci_msg;
  logic [15:0] flags;
  logic [31:0] l_addr;
  logic [7:0] l_syn;
  logic l_chan;
  logic [1:0] l_dev;
  int n_errors = 0; // Mismatches seen
  int total_checks = 0; // Comparisons made
  int cyc = 0; // Cycle count for the hang guard

  esf_error_status_flags DUT (.core_clk(core_clk), .sys_rst(sys_rst), .power_good_reset(power_good_reset),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .error_message_enables(msg_en),
    .pci_serr_enable(serr_en), .smi_thermal_enable(smi_en), .sci_thermal_enable(sci_en),
    .iso_full_evt(evt[6]), .iso_put_evt(evt[5]), .thermal_trip_evt(evt[4]), .lock_miss_evt(evt[3]),
    .throttle_evt(evt[2]), .sbe_evt(evt[0]), .mbe_evt(evt[1]), .ecc_err_addr(e_addr),
    .ecc_err_syn(e_addr[7:0]), .ecc_err_chan(e_addr[8]), .ecc_err_dev(e_addr[10:9]),
    .serr_msg(serr_msg), .smi_msg(smi_msg), .sci_msg(sci_msg), .error_status_flags(flags),
    .ecc_error_address_log(l_addr), .ecc_syndrome_log(l_syn), .ecc_channel_log(l_chan),
    .ecc_destination_log(l_dev));

  // Free-running clock
  always #5 core_clk = ~core_clk;

  // Hang guard; the whole run needs about a hundred cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      wrap_up();
    end
  end

  // Single comparison point; case inequality keeps unknowns from matching
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle event pulse; flags and messages are settled at the closing negedge
  task automatic pulse(input logic [6:0] e);
    @(negedge core_clk);
    evt = e;
    @(negedge core_clk);
    evt = 7'h00;
  endtask

  // Config write to the status register; flags update one edge later
  task automatic wr(input logic [1:0] be, input logic [15:0] d);
    @(negedge core_clk);
    cfg_wr = 1'b1;
    cfg_addr = esf_pkg::ESF_STATUS_OFFSET;
    cfg_be = be;
    cfg_wdata = d;
    @(negedge core_clk);
    cfg_wr = 1'b0;
  endtask

  // Config read; the answer stands for one cycle only, so it is sampled at once
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(negedge core_clk);
    cfg_rd = 1'b1;
    cfg_addr = a;
    cfg_be = 2'h3;
    @(negedge core_clk);
    cfg_rd = 1'b0;
    chk(cfg_rvalid, 1'b1);
    chk(cfg_rdata, exp);
  endtask

  // Logged address, syndrome and device against one failing address
  task automatic chklog(input logic [31:0] a);
    chk(l_addr, a);
    chk(l_syn, a[7:0]);
    chk(l_dev, a[10:9]);
  endtask

  // Flags read zero after power-good
  task automatic t_reset();
    rd(esf_pkg::ESF_STATUS_OFFSET, 16'h0000);
  endtask

  // Each plain event sets its own bit, messages once, clears on write-one
  task automatic t_events();
    logic [6:0] ev [6] = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h20, 7'h40};
    int pos [6] = '{0, 1, 7, 9, 13, 14};
    msg_en = 16'hffff;
    serr_en = 1'b1;
    for (int i = 0; i < 6; i++) begin
      pulse(ev[i]);
      chk(flags, 16'h0001 << pos[i]);
      chk(serr_msg, 1'b1);
      pulse(ev[i]);
      chk(serr_msg, 1'b0);
      wr(2'h3, 16'h0001 << pos[i]);
      chk(flags, 16'h0000);
    end
    // Flag must still set with the global enable off
    serr_en = 1'b0;
    pulse(7'h08);
    chk({serr_msg, flags}, 32'h0000_0200);
    wr(2'h2, 16'h0200);
  endtask

  // Thermal flag follows the message actually sent, one route at a time
  task automatic t_thermal();
    msg_en = 16'h0000;
    serr_en = 1'b1;
    smi_en = 1'b1;
    pulse(7'h10);
    chk({serr_msg, smi_msg, sci_msg, flags}, 32'h0002_0800);
    pulse(7'h10);
    chk(smi_msg, 1'b0);
    wr(2'h2, 16'h0800);
    smi_en = 1'b0;
    sci_en = 1'b1;
    pulse(7'h10);
    chk({serr_msg, smi_msg, sci_msg, flags}, 32'h0001_0800);
    wr(2'h2, 16'h0800);
    sci_en = 1'b0;
    // No route enabled: nothing is sent, so the flag stays clear
    pulse(7'h10);
    chk({serr_msg, smi_msg, sci_msg, flags}, 32'h0000_0000);
    // Error message route alone, with the other two routes off
    msg_en = 16'h0800;
    pulse(7'h10);
    chk({serr_msg, smi_msg, sci_msg, flags}, 32'h0004_0800);
    wr(2'h2, 16'h0800);
    msg_en = 16'h0000;
  endtask

  // Zero writes, reserved bits, lane masking and an unmapped offset
  task automatic t_mask();
    smi_en = 1'b1;
    pulse(7'h7f);
    chk(flags, 16'h6a83);
    wr(2'h3, 16'h0000);
    chk(flags, 16'h6a83);
    wr(2'h3, 16'h957c);
    rd(esf_pkg::ESF_STATUS_OFFSET, 16'h6a83);
    wr(2'h1, 16'hffff);
    chk(flags, 16'h6a00);
    rd(8'hc4, 16'h0000);
    wr(2'h2, 16'hffff);
    chk(flags, 16'h0000);
    smi_en = 1'b0;
  endtask

  // Locking and overwrite order of the ECC log
  task automatic t_log();
    e_addr = 32'h1111_1111;
    pulse(7'h01);
    chklog(32'h1111_1111);
    e_addr = 32'h2222_2222;
    pulse(7'h01);
    chklog(32'h1111_1111);
    e_addr = 32'h3333_3333;
    pulse(7'h02);
    chklog(32'h3333_3333);
    chk({l_chan, flags}, 32'h0001_0003);
    rd(esf_pkg::ESF_STATUS_OFFSET, 16'h0003);
    // Drop only the single-bit flag; the multi-bit lock must still hold
    wr(2'h1, 16'h0001);
    e_addr = 32'h4444_4444;
    pulse(7'h01);
    chklog(32'h3333_3333);
    chk(flags, 16'h0003);
    e_addr = 32'h5555_5555;
    pulse(7'h02);
    chklog(32'h3333_3333);
    wr(2'h1, 16'h0003);
    e_addr = 32'h6666_6666;
    pulse(7'h01);
    chklog(32'h6666_6666);
  endtask

  // Ordinary reset keeps flags and log; power-good clears both
  task automatic t_resets();
    @(negedge core_clk);
    sys_rst = 1'b1;
    @(negedge core_clk);
    sys_rst = 1'b0;
    chk(flags, 16'h0001);
    chklog(32'h6666_6666);
    power_good_reset = 1'b1;
    @(negedge core_clk);
    power_good_reset = 1'b0;
    chk(flags, 16'h0000);
    chk(l_addr, 32'h0000_0000);
  endtask

  // Verdict and end of run
  task automatic wrap_up();
    if (n_errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Main sequence: two cycles of reset, then every scenario in turn
  initial begin
    repeat (2) @(negedge core_clk);
    sys_rst = 1'b0;
    power_good_reset = 1'b0;
    t_reset();
    t_events();
    t_thermal();
    t_mask();
    t_log();
    t_resets();
    wrap_up();
  end
endmodule // tb_error_status_flags
`default_nettype wire
